//--- logic/flsc_host.sv
`timescale 1ns/1ps
// What this block does
// - Read-mode word: select bit on address 16, other bits zero.
// - Configure byte then code with upper six bits masked to zero.
// - Configure only when device is neither busy nor suspended.
// - Lock set: setup with block address, confirm inside same block.
// - Each write cycle is taken on the rising write strobe.
module flsc_host
	import flsc_pkg::*;
#(
	parameter int unsigned WE_CYCLES = WE_CYC,
	parameter int unsigned RD_CYCLES = RD_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output flsc_pins_s       flash_pins_o,
	input  wire logic [15:0] flash_dq_i,
	input  wire logic        flash_sts_i
);
	typedef enum logic [1:0] {
		S_IDLE   = 2'h0,
		S_SETUP  = 2'h1,
		S_STROBE = 2'h2,
		S_HOLD   = 2'h3
	} flsc_st_e;

	localparam logic [4:0] WE_CNT = 5'(WE_CYCLES);
	localparam logic [4:0] RD_CNT = 5'(RD_CYCLES + SYNC_LAT);

	function automatic flsc_cyc_s seq_step(flsc_op_e op, logic [1:0] step);
		flsc_cyc_s c;
		c = '{rd: 1'b0, last: 1'b1, asel: AS_ZERO, use_code: 1'b0,
			cmd: CMD_READ_STAT};
		case (op)
			OP_SUSPEND: c.cmd = CMD_SUSPEND;
			OP_RESUME: c.cmd = CMD_RESUME;
			OP_CLR_STAT: c.cmd = CMD_CLR_STAT;
			OP_CONFIG: begin
				// Status check first so busy or suspended devices are spared
				c.last = (step == 2'(CFG_STEP));
				c.rd = (step == 2'(CHK_STEP));
				c.cmd = (step == 2'h2) ? CMD_CONFIG : CMD_READ_STAT;
				c.use_code = (step == 2'(CFG_STEP));
			end
			OP_SET_LOCK: begin
				c.last = step[0];
				c.asel = AS_USER;
				c.cmd = step[0] ? CMD_LOCK_SET : CMD_LOCK_SETUP;
			end
			OP_CLR_LOCK: begin
				c.last = step[0];
				c.cmd = step[0] ? CMD_LOCK_CLR : CMD_LOCK_SETUP;
			end
			OP_RD_STAT: begin
				// Single access read; no page bursts on status
				c.last = step[0];
				c.rd = step[0];
			end
			OP_RD_ARRAY: begin
				c.last = step[0];
				c.rd = step[0];
				c.asel = AS_USER;
				c.cmd = CMD_READ_ARRAY;
			end
			OP_RD_CFG: begin
				c.last = step[0];
				c.asel = AS_RCFG;
				c.cmd = step[0] ? CMD_RCFG_SET : CMD_LOCK_SETUP;
			end
			default: c.last = 1'b1;
		endcase
		return c;
	endfunction : seq_step

	function automatic logic [31:0] lane_mask(logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// Pin synchronisers; first stage feeds only the second
	logic [15:0] dq_s1_q, dq_s2_q;
	logic        sts_s1_q, sts_s2_q, sts_s3_q;
	always_ff @(posedge clk) begin
		dq_s1_q <= flash_dq_i;
		dq_s2_q <= dq_s1_q;
		sts_s1_q <= flash_sts_i;
		sts_s2_q <= sts_s1_q;
		sts_s3_q <= sts_s2_q;
	end

	flsc_st_e    st_q, st_d;
	flsc_op_e    op_q, op_d;
	logic [1:0]  step_q, step_d;
	logic [4:0]  cnt_q, cnt_d;
	flsc_pins_s  pins_q, pins_d;
	logic [23:0] addr_q, addr_d;
	logic [15:0] data_q, data_d, rdata_q, rdata_d;
	logic [1:0]  mode_q, mode_d;
	logic        susp_q, susp_d, refused_q, refused_d, pulse_q, pulse_d;
	logic        hrst_q, hrst_d, ack_q, ack_d;
	logic [31:0] dat_q, dat_d, wm, ctrl_w;
	logic        take, wr_ctrl, wr_stat;
	flsc_cyc_s   cur;

	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign flash_pins_o = pins_q;

	always_comb begin
		take = wb_cyc_i & wb_stb_i & ~ack_q;
		wm = lane_mask(wb_sel_i);
		ctrl_w = wb_dat_i & wm;
		wr_ctrl = take & wb_we_i & (wb_adr_i == REG_CTRL);
		wr_stat = take & wb_we_i & (wb_adr_i == REG_STAT);
		cur = seq_step(op_q, step_q);
		st_d = st_q;
		op_d = op_q;
		step_d = step_q;
		cnt_d = cnt_q;
		pins_d = pins_q;
		addr_d = addr_q;
		data_d = data_q;
		rdata_d = rdata_q;
		mode_d = mode_q;
		susp_d = susp_q;
		hrst_d = hrst_q;
		ack_d = take;
		dat_d = 32'h0000_0000;
		refused_d = refused_q & ~(wr_stat & ctrl_w[STAT_REFUSED]);
		pulse_d = pulse_q & ~(wr_stat & ctrl_w[STAT_PULSE]);
		if (take & wb_we_i & (wb_adr_i == REG_ADDR))
			addr_d = 24'((32'(addr_q) & ~wm) | (wb_dat_i & wm));
		if (take & wb_we_i & (wb_adr_i == REG_DATA))
			data_d = 16'((32'(data_q) & ~wm) | (wb_dat_i & wm));
		if (wr_ctrl & wm[CTRL_RST_BIT])
			hrst_d = wb_dat_i[CTRL_RST_BIT];
		if (take & ~wb_we_i) begin
			case (wb_adr_i)
				REG_CTRL: dat_d[CTRL_RST_BIT] = hrst_q;
				REG_ADDR: dat_d = 32'(addr_q);
				REG_DATA: dat_d = 32'(data_q);
				REG_STAT: begin
					dat_d[STAT_BUSY] = (st_q != S_IDLE);
					dat_d[STAT_REFUSED] = refused_q;
					dat_d[STAT_SUSP] = susp_q;
					dat_d[STAT_PULSE] = pulse_q;
					dat_d[STAT_PIN] = sts_s2_q;
					dat_d[STAT_MODE+1:STAT_MODE] = mode_q;
					dat_d[STAT_RDATA+15:STAT_RDATA] = rdata_q;
				end
				default: dat_d = 32'h0000_0000;
			endcase
		end
		// Falling pin edge in a pulse mode marks a finished operation
		if ((mode_q != CFG_LEVEL) & sts_s3_q & ~sts_s2_q)
			pulse_d = 1'b1;
		// Device drops pin configuration on hard reset
		if (hrst_q) begin
			mode_d = CFG_LEVEL;
			susp_d = 1'b0;
		end
		pins_d.rst_n = ~hrst_q;
		case (st_q)
			S_IDLE: begin
				if (wr_ctrl & wm[0] & (ctrl_w[3:0] != OP_NONE)) begin
					op_d = flsc_op_e'(ctrl_w[3:0]);
					step_d = 2'h0;
					st_d = S_SETUP;
					// Set lock, clear lock and suspend refused while suspended
					if (susp_q & (ctrl_w[3:0] == OP_SET_LOCK |
						ctrl_w[3:0] == OP_CLR_LOCK |
						ctrl_w[3:0] == OP_SUSPEND)) begin
						st_d = S_IDLE;
						refused_d = 1'b1;
					end
				end else if (wr_ctrl & wm[0]) begin
					refused_d = refused_d;
				end
			end
			S_SETUP: begin
				case (cur.asel)
					AS_USER: pins_d.addr = addr_q;
					AS_RCFG: begin
						pins_d.addr = 24'h00_0000;
						pins_d.addr[RM_ADDR_BIT] = data_q[0];
					end
					default: pins_d.addr = 24'h00_0000;
				endcase
				pins_d.dq = {8'h00, cur.use_code ?
					(data_q[7:0] & CFG_CODE_MASK) : cur.cmd};
				pins_d.dq_oe = ~cur.rd;
				pins_d.ce_n = 1'b0;
				cnt_d = cur.rd ? RD_CNT : WE_CNT;
				st_d = S_STROBE;
			end
			S_STROBE: begin
				pins_d.we_n = cur.rd;
				pins_d.oe_n = ~cur.rd;
				cnt_d = cnt_q - 5'h01;
				// Strobe stays low for the full count before it rises
				if (cnt_q == 5'h00) begin
					// Write taken on this rising strobe edge
					pins_d.we_n = 1'b1;
					pins_d.oe_n = 1'b1;
					if (cur.rd)
						rdata_d = dq_s2_q;
					st_d = S_HOLD;
				end
			end
			default: begin
				pins_d.ce_n = 1'b1;
				pins_d.dq_oe = 1'b0;
				st_d = cur.last ? S_IDLE : S_SETUP;
				step_d = step_q + 2'h1;
				if (op_q == OP_RD_STAT)
					susp_d = rdata_q[SR_READY] & rdata_q[SR_SUSP];
				if (op_q == OP_RESUME)
					susp_d = 1'b0;
				if (op_q == OP_CONFIG & step_q == 2'(CHK_STEP) &
					(~rdata_q[SR_READY] | rdata_q[SR_SUSP] | susp_q)) begin
					st_d = S_IDLE;
					refused_d = 1'b1;
				end
				if (op_q == OP_CONFIG & cur.last)
					mode_d = data_q[1:0];
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= S_IDLE;
			op_q <= OP_NONE;
			step_q <= 2'h0;
			cnt_q <= 5'h00;
			pins_q <= '{addr: 24'h00_0000, dq: 16'h0000, dq_oe: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1};
			addr_q <= 24'h00_0000;
			data_q <= 16'h0000;
			rdata_q <= 16'h0000;
			mode_q <= CFG_LEVEL;
			susp_q <= 1'b0;
			refused_q <= 1'b0;
			pulse_q <= 1'b0;
			hrst_q <= 1'b0;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			step_q <= step_d;
			cnt_q <= cnt_d;
			pins_q <= pins_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			mode_q <= mode_d;
			susp_q <= susp_d;
			refused_q <= refused_d;
			pulse_q <= pulse_d;
			hrst_q <= hrst_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_code_mask;
		$rose(pins_q.we_n) && op_q == OP_CONFIG && step_q == 2'h3
			|-> pins_q.dq[15:2] == 14'h0000;
	endproperty
	a_code_mask: assert property (p_code_mask)
		else $error("configuration code not masked");

	property p_cfg_guard;
		$rose(pins_q.we_n) && pins_q.dq[7:0] == CMD_CONFIG
			&& op_q == OP_CONFIG
			|-> rdata_q[SR_READY] && !rdata_q[SR_SUSP] && !susp_q;
	endproperty
	a_cfg_guard: assert property (p_cfg_guard)
		else $error("configure issued while busy or suspended");

	property p_lock_addr;
		$rose(pins_q.we_n) && op_q == OP_SET_LOCK |-> pins_q.addr == addr_q;
	endproperty
	a_lock_addr: assert property (p_lock_addr)
		else $error("lock write not at block address");

	property p_we_stable;
		$rose(pins_q.we_n) |-> $stable(pins_q.addr) && $stable(pins_q.dq)
			&& pins_q.dq_oe && !pins_q.ce_n;
	endproperty
	a_we_stable: assert property (p_we_stable)
		else $error("address or data moved at write strobe rise");

	property p_we_width;
		$fell(pins_q.we_n) |-> !pins_q.we_n [*3] ##1 pins_q.we_n;
	endproperty
	a_we_width: assert property (p_we_width)
		else $error("write strobe width wrong");

	property p_rcfg_zero;
		!pins_q.ce_n && op_q == OP_RD_CFG
			|-> pins_q.addr[15:0] == 16'h0000 && pins_q.addr[23:17] == 7'h00;
	endproperty
	a_rcfg_zero: assert property (p_rcfg_zero)
		else $error("reserved read mode bits not zero");

	property p_susp_block;
		susp_q && $rose(pins_q.we_n)
			|-> pins_q.dq[7:0] != CMD_LOCK_SETUP && pins_q.dq[7:0] != CMD_SUSPEND;
	endproperty
	a_susp_block: assert property (p_susp_block)
		else $error("illegal command while suspended");

	property p_resume_clr;
		$rose(pins_q.we_n) && op_q == OP_RESUME |-> ##[1:2] !susp_q;
	endproperty
	a_resume_clr: assert property (p_resume_clr)
		else $error("suspended shadow not cleared on resume");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held over two cycles");

	property p_no_overlap;
		!(!pins_q.we_n && !pins_q.oe_n);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("read and write strobes overlap");

	c_config: cover property (op_q == OP_CONFIG && st_q == S_HOLD && cur.last);
	c_lock: cover property (op_q == OP_SET_LOCK && $rose(pins_q.we_n));
	c_resume: cover property (op_q == OP_RESUME && $rose(pins_q.we_n));
	c_refuse: cover property ($rose(refused_q));
endmodule : flsc_host

//--- logic/flsc_pkg.sv
package flsc_pkg;
	// Register byte offsets on the host Wishbone port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hC;
	localparam int unsigned CTRL_RST_BIT = 8;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_REFUSED = 1;
	localparam int unsigned STAT_SUSP = 2;
	localparam int unsigned STAT_PULSE = 3;
	localparam int unsigned STAT_PIN = 4;
	localparam int unsigned STAT_MODE = 5;
	localparam int unsigned STAT_RDATA = 16;
	// Status register bits of the flash
	localparam int unsigned SR_READY = 7;
	localparam int unsigned SR_SUSP = 2;
	// Flash command bytes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STAT = 8'h70;
	localparam logic [7:0] CMD_CLR_STAT = 8'h50;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'hD0;
	localparam logic [7:0] CMD_CONFIG = 8'hB8;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_SET = 8'h01;
	localparam logic [7:0] CMD_LOCK_CLR = 8'hD0;
	localparam logic [7:0] CMD_RCFG_SET = 8'h03;
	localparam logic [7:0] CFG_CODE_MASK = 8'h03;
	localparam logic [1:0] CFG_LEVEL = 2'h0;
	localparam int unsigned RM_ADDR_BIT = 16;
	localparam int unsigned CFG_STEP = 3;
	localparam int unsigned CHK_STEP = 1;
	// Bus timing
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned T_WE_NS = 70;
	localparam int unsigned T_RD_NS = 150;
	localparam int unsigned SYNC_LAT = 2;
	localparam int unsigned WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_SUSPEND  = 4'h1,
		OP_RESUME   = 4'h2,
		OP_CONFIG   = 4'h3,
		OP_SET_LOCK = 4'h4,
		OP_CLR_LOCK = 4'h5,
		OP_RD_STAT  = 4'h6,
		OP_CLR_STAT = 4'h7,
		OP_RD_ARRAY = 4'h8,
		OP_RD_CFG   = 4'h9
	} flsc_op_e;

	typedef enum logic [1:0] {
		AS_ZERO = 2'h0,
		AS_USER = 2'h1,
		AS_RCFG = 2'h2
	} flsc_asel_e;

	typedef struct packed {
		logic       rd;
		logic       last;
		flsc_asel_e asel;
		logic       use_code;
		logic [7:0] cmd;
	} flsc_cyc_s;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] dq;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        rst_n;
	} flsc_pins_s;
endpackage : flsc_pkg

//--- logic/unused_none.sv
`timescale 1ns/1ps

//--- sim/flsc_flash_model.sv
`timescale 1ns/1ps
module flsc_flash_model
	import flsc_pkg::*;
(
	input  flsc_pins_s   pins,
	input  wire logic    program_enable_voltage_ok,
	input  wire logic    prog_go,
	output logic [15:0]  dq,
	output logic         sts,
	output logic [1:0]   mode,
	output logic [127:0] locks
);
	logic [7:0]  sr = 8'h80;
	logic [1:0]  pend = 0;
	logic [15:0] val;
	logic [15:0] held = 0;
	logic        busy = 0, susp = 0, prog = 0, rd_stat = 0, pls_n = 1;
	initial mode = 0;
	initial locks = '0;
	assign sts = (mode == 0) ? !busy : pls_n;
	assign val = rd_stat ? {8'h00, sr} : ~pins.addr[15:0];
	always @* if (!pins.ce_n && !pins.oe_n) held = val;
	// Released bus shows the inverse, never a stale copy
	assign dq = (!pins.ce_n && !pins.oe_n) ? val : ~held;
	task automatic run(input logic [1:0] kind, input int steps);
		busy = 1;
		sr[7] = 0;
		prog = kind[1];
		repeat (steps) begin
			#100;
			wait (!susp);
		end
		busy = 0;
		prog = 0;
		sr[7] = 1;
		if (|(mode & kind)) begin
			pls_n = 0;
			#250 pls_n = 1;
		end
	endtask : run
	task automatic cmd(input logic [7:0] c, input logic [23:0] a);
		if (pend == 1) begin
			pend = 0;
			if (c > 8'h03) sr[5:4] = 2'b11;
			else mode = c[1:0];
		end else if (pend == 2) begin
			pend = 0;
			if (c == 8'h03) ;
			else if (c != 8'h01 && c != 8'hD0) sr[5:4] = 2'b11;
			else if (!program_enable_voltage_ok) sr = sr | ((c == 8'h01) ? 8'h18 : 8'h28);
			else begin
				if (c == 8'h01) locks[a[23:17]] = 1'b1;
				else locks = '0;
				fork run(2'b00, 10); join_none
			end
		end else case (c)
			8'hB0: if (prog && !susp) fork begin
				#300 susp = 1;
				busy = 0;
				sr[7] = 1;
				sr[2] = 1;
			end join_none
			8'hD0: if (susp) begin
				susp = 0;
				busy = 1;
				sr[7] = 0;
				sr[2] = 0;
			end
			8'hB8: if (busy || susp) sr[5:4] = 2'b11; else pend = 1;
			8'h60: if (busy || susp) sr[5:4] = 2'b11; else pend = 2;
			8'h50: sr[5:1] = 0;
			default: ;
		endcase
		rd_stat = (c != 8'hFF);
	endtask : cmd
	// Bench kicks off a program run that suspend can interrupt
	always @(posedge prog_go)
		if (!busy && !susp) fork run(2'b10, 20); join_none
	always @(posedge pins.we_n)
		if (!pins.ce_n && pins.rst_n) cmd(pins.dq[7:0], pins.addr);
	always @(negedge pins.rst_n) begin
		mode = 0;
		susp = 0;
		busy = 0;
		pend = 0;
		sr = 8'h80;
	end
endmodule : flsc_flash_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import flsc_pkg::*;
	logic         clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
	logic [3:0]   adr = 0, sel = 0;
	logic [31:0]  dat = 0, rdat, r, a;
	logic         ack, sts, program_enable_voltage_ok = 1, prog_go = 0;
	logic [15:0]  dq;
	logic [1:0]   mode;
	logic [127:0] locks;
	logic [6:0]   blk;
	flsc_pins_s   pins;
	logic [3:0]   ref_ops [4] = '{4'h1, 4'h4, 4'h5, 4'h3};
	int           failures = 0, tests_run = 0, i, seed = 32'hA9068242;
	always #12.5 clk = ~clk;
	flsc_host flsc_host_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.flash_pins_o(pins), .flash_dq_i(dq), .flash_sts_i(sts));
	flsc_flash_model flsc_flash_model_inst (.pins(pins), .program_enable_voltage_ok(program_enable_voltage_ok),
		.prog_go(prog_go), .dq(dq), .sts(sts), .mode(mode), .locks(locks));
	function automatic logic [31:0] srx(input logic rd, sp,
		input logic [2:0] e);
		return {24'h0, rd, 1'b0, e, sp, 2'b00};
	endfunction : srx
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1; stb <= 1; we <= w; adr <= ad; dat <= d; sel <= 4'hF;
		// Look at ack mid-cycle, act on the next rising edge
		do begin @(negedge clk); n++; end while (ack !== 1'b1 && n < 50);
		r = rdat;
		@(posedge clk);
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk);
		if (n >= 50) begin failures++; report_and_stop(); end
	endtask : wb
	task automatic op(input logic [3:0] o, input logic [31:0] ad, d);
		int n;
		n = 0;
		wb(1, REG_ADDR, ad);
		wb(1, REG_DATA, d);
		wb(1, REG_CTRL, {28'h0, o});
		do begin wb(0, REG_STAT, 0); n++; end
		while (r[STAT_BUSY] !== 1'b0 && n < 100);
		if (n >= 100) begin failures++; report_and_stop(); end
	endtask : op
	// Host side waits on the ready bit, as software would
	task automatic poll_ready;
		int n;
		n = 0;
		do begin op(6, 0, 0); n++; end
		while (r[16 + SR_READY] !== 1'b1 && n < 100);
		if (n >= 100) begin failures++; report_and_stop(); end
	endtask : poll_ready
	task automatic pulse_prog;
		prog_go <= 1;
		@(posedge clk);
		prog_go <= 0;
		@(posedge clk);
	endtask : pulse_prog
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		wb(0, REG_STAT, 0);
		chk("stat_reset", 32'h10, r);
		wb(0, 4'h2, 0);
		chk("unmapped", 0, r);
		op(9, 0, 1);
		op(6, 0, 0);
		chk("rcfg_ignored", srx(1, 0, 0), r[31:16]);
		a = $random(seed);
		op(8, a, 0);
		chk("array", {16'h0, ~a[15:0]}, r[31:16]);
		$display("test basic done");
		pulse_prog();
		op(1, 0, 0);
		poll_ready();
		chk("susp_sr", srx(1, 1, 0), r[31:16]);
		chk("susp_stat", 32'h14, r & 32'h7F);
		for (i = 0; i < 4; i++) begin
			op(ref_ops[i], 0, 0);
			chk("refused", 32'h2, r & 32'h3);
			wb(1, REG_STAT, 32'h2);
		end
		chk("locks_kept", 0, {31'h0, |locks});
		op(2, 0, 0);
		op(6, 0, 0);
		chk("resumed_sr", srx(0, 0, 0), r[31:16]);
		chk("resumed_pin", 0, {31'h0, r[STAT_PIN]});
		poll_ready();
		chk("prog_done", srx(1, 0, 0), r[31:16]);
		$display("test suspend done");
		for (i = 0; i < 4; i++) begin
			op(3, 0, ($random(seed) & 32'hFFFF_FFFC) | 32'(i));
			chk("pin_mode", 32'(i), {30'h0, mode});
			chk("mode_shadow", 32'(i), {30'h0, r[6:5]});
			pulse_prog();
			poll_ready();
			repeat (20) @(posedge clk);
			wb(0, REG_STAT, 0);
			chk("pulse_seen", {31'h0, i[1]}, {31'h0, r[STAT_PULSE]});
			wb(1, REG_STAT, 32'h8);
		end
		wb(1, REG_CTRL, 32'h100);
		repeat (3) @(posedge clk);
		chk("rst_pin", 0, {31'h0, pins.rst_n});
		wb(1, REG_CTRL, 0);
		wb(0, REG_STAT, 0);
		chk("mode_after_rst", 0, {28'h0, mode, r[6:5]});
		$display("test config done");
		blk = 7'($random(seed));
		op(4, {8'h0, blk, 17'h0} | ($random(seed) & 32'h1FFFF), 0);
		poll_ready();
		chk("lock_sr", srx(1, 0, 0), r[31:16]);
		chk("lock_bit", 1, {31'h0, locks[blk]});
		program_enable_voltage_ok <= 0;
		op(4, {8'h0, blk + 7'h1, 17'h0}, 0);
		op(6, 0, 0);
		chk("lock_vlow", srx(1, 0, 3'b011), r[31:16]);
		chk("lock_vlow_bit", 0, {31'h0, locks[blk + 7'h1]});
		op(7, 0, 0);
		op(5, 0, 0);
		op(6, 0, 0);
		chk("clr_vlow", srx(1, 0, 3'b101), r[31:16]);
		chk("clr_vlow_bit", 1, {31'h0, locks[blk]});
		program_enable_voltage_ok <= 1;
		op(7, 0, 0);
		op(5, 0, 0);
		poll_ready();
		chk("clr_sr", srx(1, 0, 0), r[31:16]);
		chk("clr_bits", 0, {31'h0, |locks});
		$display("test locks done");
		report_and_stop();
	end
endmodule : tb_top
